// *** hdl/scs_switcher.sv ***
// System clock source switcher with APB register access.
// Assumes oscillator models outside report ready levels in pclk domain.
`default_nettype none
module scs_switcher
    import scs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [4:0]  osc_ready_pin,
    input  wire logic        new_clk_pin,
    output logic      [4:0]  osc_enable,
    output logic      [2:0]  sys_clk_sel,
    output logic             cpu_stall,
    output logic             irq
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    logic [5:0] stable_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg  <= 6'h00;
            sync2_reg  <= 6'h00;
            sync3_reg  <= 6'h00;
            stable_reg <= 6'h00;
        end else begin
            sync1_reg <= {new_clk_pin, osc_ready_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 6; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    stable_reg[i] <= sync3_reg[i];
                end
            end
        end
    end
    logic [4:0] osc_ready;
    logic       new_clk_s;
    logic       new_clk_d_reg;
    logic       new_clk_rise;
    assign osc_ready    = stable_reg[4:0];
    assign new_clk_s    = stable_reg[5];
    assign new_clk_rise = new_clk_s && !new_clk_d_reg;
    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic apb_wr;
    logic apb_rd;
    logic hit;
    assign pready  = 1'b1;
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && penable && !pwrite;
    assign hit     = (paddr == SCS_OFF_CTRL) || (paddr == SCS_OFF_KEY) ||
                     (paddr == SCS_OFF_CFG) || (paddr == SCS_OFF_IRQ_STAT) ||
                     (paddr == SCS_OFF_IRQ_MASK) || (paddr == SCS_OFF_OSC_RUN);
    assign pslverr = psel && penable && !hit;
    // ------------------------------------------------------------------
    // Unlock key sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SCS_K_IDLE, SCS_K_HALF, SCS_K_OPEN} scs_key_t;
    scs_key_t key_reg;
    logic     ctrl_wr;
    assign ctrl_wr = apb_wr && (paddr == SCS_OFF_CTRL) && (key_reg == SCS_K_OPEN);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_reg <= SCS_K_IDLE;
        end else if (apb_wr && paddr == SCS_OFF_KEY) begin
            if (pwdata == SCS_KEY1) begin
                key_reg <= SCS_K_HALF;
            end else if (pwdata == SCS_KEY2 && key_reg == SCS_K_HALF) begin
                key_reg <= SCS_K_OPEN;
            end else begin
                key_reg <= SCS_K_IDLE;
            end
        end else if (apb_wr) begin
            key_reg <= SCS_K_IDLE;
        end
    end
    // ------------------------------------------------------------------
    // Configuration and oscillator enables
    // ------------------------------------------------------------------
    logic [2:0] cfg_reg;
    logic       sw_enabled;
    assign sw_enabled = !cfg_reg[SCS_CFG_SWDIS_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= SCS_RST_CFG;
        end else if (apb_wr && paddr == SCS_OFF_CFG && pstrb[0]) begin
            cfg_reg <= pwdata[2:0];
        end
    end
    // Oscillator index per source code: 0 pri, 1 sec, 2 frc, 3 dco, 4 low_power_rc_osc.
    function automatic logic [2:0] scs_osc_idx(input logic [2:0] src);
        unique case (src)
            SCS_SRC_PRI, SCS_SRC_PRIPLL: scs_osc_idx = 3'h0;
            SCS_SRC_SEC:                 scs_osc_idx = 3'h1;
            SCS_SRC_LOW_POWER_RC_OSC:                scs_osc_idx = 3'h4;
            SCS_SRC_DCO:                 scs_osc_idx = 3'h3;
            default:                     scs_osc_idx = 3'h2;
        endcase
    endfunction
    // ------------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCS_S_IDLE, SCS_S_START, SCS_S_OST, SCS_S_PLL, SCS_S_SETTLE, SCS_S_SWAP
    } scs_state_t;
    scs_state_t state_reg;
    scs_ctrl_t  ctrl_reg;
    logic [10:0] timer_reg;
    logic [3:0]  settle_reg;
    logic        started_reg;
    logic [2:0]  new_idx;
    logic [2:0]  old_idx;
    logic        is_pll;
    logic        ev_done;
    logic        ev_abort;
    assign new_idx  = scs_osc_idx(ctrl_reg.nxt);
    assign old_idx  = scs_osc_idx(ctrl_reg.cur);
    assign is_pll   = (ctrl_reg.nxt == SCS_SRC_FAST_RC_PLL_MODE) || (ctrl_reg.nxt == SCS_SRC_PRIPLL);
    assign ev_done  = (state_reg == SCS_S_SWAP);
    assign ev_abort = (state_reg == SCS_S_IDLE) && ctrl_reg.req &&
                      (ctrl_reg.cur == ctrl_reg.nxt);
    assign cpu_stall = 1'b0;
    assign sys_clk_sel = ctrl_reg.cur;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SCS_S_IDLE;
        end else begin
            unique case (state_reg)
                SCS_S_IDLE: begin
                    if (ctrl_reg.req && ctrl_reg.cur != ctrl_reg.nxt) begin
                        state_reg <= SCS_S_START;
                    end
                end
                SCS_S_START: begin
                    if (started_reg && new_idx == 3'h0) begin
                        state_reg <= SCS_S_OST;
                    end else if (is_pll) begin
                        state_reg <= SCS_S_PLL;
                    end else if (osc_ready[new_idx]) begin
                        state_reg <= SCS_S_SETTLE;
                    end
                end
                SCS_S_OST: begin
                    if (timer_reg == 11'(SCS_OST_CYCLES) && osc_ready[new_idx]) begin
                        state_reg <= is_pll ? SCS_S_PLL : SCS_S_SETTLE;
                    end
                end
                SCS_S_PLL: begin
                    if (ctrl_reg.lock) begin
                        state_reg <= SCS_S_SETTLE;
                    end
                end
                SCS_S_SETTLE: begin
                    if (settle_reg == 4'(SCS_SETTLE_CYCLES)) begin
                        state_reg <= SCS_S_SWAP;
                    end
                end
                SCS_S_SWAP: state_reg <= SCS_S_IDLE;
                default: state_reg <= SCS_S_IDLE;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg     <= 11'h000;
            settle_reg    <= 4'h0;
            new_clk_d_reg <= 1'b0;
        end else begin
            new_clk_d_reg <= new_clk_s;
            if (state_reg == SCS_S_OST || state_reg == SCS_S_PLL) begin
                if (timer_reg != 11'(SCS_OST_CYCLES)) begin
                    timer_reg <= timer_reg + 11'h001;
                end
            end else begin
                timer_reg <= 11'h000;
            end
            if (state_reg != SCS_S_SETTLE) begin
                settle_reg <= 4'h0;
            end else if (new_clk_rise) begin
                settle_reg <= settle_reg + 4'h1;
            end
        end
    end
    // Oscillator enable bits, one per oscillator; bit 2 is the fast RC.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_enable  <= 5'h04;
            started_reg <= 1'b0;
        end else begin
            if (state_reg == SCS_S_IDLE && ctrl_reg.req && ctrl_reg.cur != ctrl_reg.nxt) begin
                started_reg <= !osc_enable[new_idx];
                osc_enable[new_idx] <= 1'b1;
            end else if (state_reg == SCS_S_SWAP && old_idx != new_idx) begin
                if (!((old_idx == 3'h4) && (cfg_reg[SCS_CFG_WDT_BIT] || cfg_reg[SCS_CFG_FSM_BIT]))
                    && !((old_idx == 3'h1) && ctrl_reg.sec_en)) begin
                    osc_enable[old_idx] <= 1'b0;
                end
            end
            if (ctrl_reg.sec_en) begin
                osc_enable[1] <= 1'b1;
            end
        end
    end
    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Software may only raise the request through CTRL; hardware or the CFG switch-disable
    // bit ends it, so a stray zero written mid-switch cannot cut a sequence short.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '{cur: SCS_RST_SRC, nxt: SCS_RST_SRC, lock: 1'b0,
                          fail: 1'b0, sec_en: 1'b0, req: 1'b0};
        end else begin
            if (ctrl_wr && pstrb[1] && sw_enabled) begin
                ctrl_reg.nxt <= pwdata[SCS_NXT_LSB +: 3];
            end
            if (ctrl_wr && pstrb[0]) begin
                ctrl_reg.sec_en <= pwdata[SCS_SECONDARY_OSC_ENABLE_BIT];
                if (pwdata[SCS_REQ_BIT] && sw_enabled) begin
                    ctrl_reg.req <= 1'b1;
                end
            end
            if (!sw_enabled) begin
                ctrl_reg.req <= 1'b0;
            end else if (ev_abort || ev_done) begin
                ctrl_reg.req <= 1'b0;
            end
            if (ev_done) begin
                ctrl_reg.cur <= ctrl_reg.nxt;
            end
            if (state_reg == SCS_S_IDLE && ctrl_reg.req && ctrl_reg.cur != ctrl_reg.nxt) begin
                ctrl_reg.lock <= 1'b0;
                ctrl_reg.fail <= 1'b0;
            end else if (state_reg == SCS_S_PLL && timer_reg >= 11'(SCS_PLL_CYCLES)
                         && osc_ready[new_idx]) begin
                ctrl_reg.lock <= 1'b1;
            end else if (ctrl_reg.cur != SCS_SRC_FAST_RC_PLL_MODE && ctrl_reg.cur != SCS_SRC_PRIPLL
                         && state_reg == SCS_S_IDLE) begin
                ctrl_reg.lock <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [SCS_IRQ_W-1:0] stat_reg;
    logic [SCS_IRQ_W-1:0] mask_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= '0;
            mask_reg <= '0;
        end else begin
            if (apb_wr && paddr == SCS_OFF_IRQ_MASK) begin
                mask_reg <= pwdata[SCS_IRQ_W-1:0];
            end
            // Set wins over a simultaneous write-one clear.
            stat_reg <= (stat_reg & ~((apb_wr && paddr == SCS_OFF_IRQ_STAT) ?
                        pwdata[SCS_IRQ_W-1:0] : 2'h0)) | {ev_abort, ev_done};
        end
    end
    assign irq = |(stat_reg & mask_reg);
    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
                SCS_OFF_CTRL: begin
                    prdata[SCS_CUR_LSB +: 3] <= ctrl_reg.cur;
                    prdata[SCS_NXT_LSB +: 3] <= ctrl_reg.nxt;
                    prdata[SCS_LOCK_BIT]     <= ctrl_reg.lock;
                    prdata[SCS_FAIL_BIT]     <= ctrl_reg.fail;
                    prdata[SCS_SECONDARY_OSC_ENABLE_BIT]   <= ctrl_reg.sec_en;
                    prdata[SCS_REQ_BIT]      <= ctrl_reg.req;
                end
                SCS_OFF_CFG:      prdata[2:0] <= cfg_reg;
                SCS_OFF_IRQ_STAT: prdata[SCS_IRQ_W-1:0] <= stat_reg;
                SCS_OFF_IRQ_MASK: prdata[SCS_IRQ_W-1:0] <= mask_reg;
                SCS_OFF_OSC_RUN:  prdata[4:0] <= osc_enable;
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_abort_clears;
        @(posedge pclk) disable iff (!presetn)
        ev_abort |=> !ctrl_reg.req && state_reg == SCS_S_IDLE;
    endproperty
    a_abort_clears: assert property (p_abort_clears) else $error("redundant request kept");
    property p_flags_cleared;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == SCS_S_IDLE && $rose(state_reg == SCS_S_START)) or
        (state_reg == SCS_S_START && $past(state_reg) == SCS_S_IDLE)
            |-> !ctrl_reg.lock && !ctrl_reg.fail;
    endproperty
    a_flags_cleared: assert property (p_flags_cleared) else $error("lock or fail not cleared");
    property p_enable_new;
        @(posedge pclk) disable iff (!presetn)
        state_reg == SCS_S_START |-> osc_enable[new_idx];
    endproperty
    a_enable_new: assert property (p_enable_new) else $error("new oscillator off");
    property p_ost_wait;
        @(posedge pclk) disable iff (!presetn)
        state_reg == SCS_S_OST && timer_reg != 11'(SCS_OST_CYCLES) |=> state_reg == SCS_S_OST;
    endproperty
    a_ost_wait: assert property (p_ost_wait) else $error("startup timer skipped");
    property p_pll_wait;
        @(posedge pclk) disable iff (!presetn)
        state_reg == SCS_S_PLL && !ctrl_reg.lock |=> state_reg == SCS_S_PLL;
    endproperty
    a_pll_wait: assert property (p_pll_wait) else $error("left pll wait unlocked");
    property p_settle_ten;
        @(posedge pclk) disable iff (!presetn)
        state_reg == SCS_S_SWAP |-> $past(settle_reg) == 4'(SCS_SETTLE_CYCLES);
    endproperty
    a_settle_ten: assert property (p_settle_ten) else $error("settle count wrong");
    property p_swap_done;
        @(posedge pclk) disable iff (!presetn)
        state_reg == SCS_S_SWAP |=> !ctrl_reg.req && ctrl_reg.cur == $past(ctrl_reg.nxt);
    endproperty
    a_swap_done: assert property (p_swap_done) else $error("swap not completed");
    property p_disabled_req;
        @(posedge pclk) disable iff (!presetn)
        !sw_enabled |=> !ctrl_reg.req;
    endproperty
    a_disabled_req: assert property (p_disabled_req) else $error("request while disabled");
    property p_low_power_rc_osc_kept;
        @(posedge pclk) disable iff (!presetn)
        state_reg == SCS_S_SWAP && old_idx == 3'h4 && cfg_reg[SCS_CFG_WDT_BIT]
            |=> osc_enable[4];
    endproperty
    a_low_power_rc_osc_kept: assert property (p_low_power_rc_osc_kept) else $error("low power rc stopped");
    property p_c_switch;
        @(posedge pclk) disable iff (!presetn)
        state_reg == SCS_S_SETTLE ##[1:300] state_reg == SCS_S_SWAP;
    endproperty
    c_switch: cover property (p_c_switch);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn) ev_abort);
    c_pll: cover property (@(posedge pclk) disable iff (!presetn) state_reg == SCS_S_PLL);
endmodule // scs_switcher
`default_nettype wire

// *** hdl/scs_pkg.sv ***
// Constants and types for the system clock switcher.
// Assumes one pclk domain and an APB master with 32-bit data.
`default_nettype none
package scs_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] SCS_OFF_CTRL     = 8'h00;
    localparam logic [7:0] SCS_OFF_KEY      = 8'h04;
    localparam logic [7:0] SCS_OFF_CFG      = 8'h08;
    localparam logic [7:0] SCS_OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] SCS_OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] SCS_OFF_OSC_RUN  = 8'h14;
    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int SCS_CUR_LSB   = 12;
    localparam int SCS_NXT_LSB   = 8;
    localparam int SCS_LOCK_BIT  = 5;
    localparam int SCS_FAIL_BIT  = 3;
    localparam int SCS_SECONDARY_OSC_ENABLE_BIT = 1;
    localparam int SCS_REQ_BIT   = 0;
    // Configuration register bits.
    localparam int SCS_CFG_SWDIS_BIT = 0;
    localparam int SCS_CFG_WDT_BIT   = 1;
    localparam int SCS_CFG_FSM_BIT   = 2;
    // Unlock keys, written in order to the key register.
    localparam logic [31:0] SCS_KEY1 = 32'h0000_0057;
    localparam logic [31:0] SCS_KEY2 = 32'h0000_00AA;
    // Reset values.
    localparam logic [2:0] SCS_RST_SRC   = 3'h0;
    localparam logic [2:0] SCS_RST_CFG   = 3'h1;
    // Status bits: 0 done, 1 redundant abort.
    localparam int SCS_IRQ_W = 2;
    // Timing.
    localparam int SCS_SETTLE_CYCLES = 10;
    localparam int SCS_OST_CYCLES    = 1024;
    localparam int SCS_PLL_CYCLES    = 64;
    // ------------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCS_SRC_FRC    = 3'h0,
        SCS_SRC_FAST_RC_PLL_MODE = 3'h1,
        SCS_SRC_PRI    = 3'h2,
        SCS_SRC_PRIPLL = 3'h3,
        SCS_SRC_SEC    = 3'h4,
        SCS_SRC_LOW_POWER_RC_OSC   = 3'h5,
        SCS_SRC_DCO    = 3'h6,
        SCS_SRC_FRCDIV = 3'h7
    } scs_src_t;
    typedef struct packed {
        logic [2:0] cur;
        logic [2:0] nxt;
        logic       lock;
        logic       fail;
        logic       sec_en;
        logic       req;
    } scs_ctrl_t;
endpackage
`default_nettype wire

// *** verif/scs_tb.sv ***
// Self-checking bench for the system clock switcher, driven over APB.
// Assumes one 100 MHz pclk and oscillators that report ready a cycle after enable.
`default_nettype none
module tb
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, new_clk_pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr, cpu_stall, irq, sec;
    logic [4:0]  osc_ready_pin, osc_enable, en;
    logic [2:0]  sys_clk_sel, cur, cfg;
    logic [32:0] exp_q[$], msk_q[$];
    int          miscompares, cmp_count;

    scs_switcher uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_ready_pin(osc_ready_pin),
        .new_clk_pin(new_clk_pin), .osc_enable(osc_enable), .sys_clk_sel(sys_clk_sel),
        .cpu_stall(cpu_stall), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Oscillators come up one cycle after they are enabled.
    always @(posedge pclk) osc_ready_pin <= osc_enable;
    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each completed access takes the oldest note; the mask hides don't-care bits.
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            chk("apb response", {pslverr, prdata} & msk_q[0], exp_q[0]);
            exp_q.pop_front();
            msk_q.pop_front();
        end
    end
    // ------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] m);
        int n;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
    endtask
    task automatic unlock();
        wr(SCS_OFF_KEY, SCS_KEY1);
        wr(SCS_OFF_KEY, SCS_KEY2);
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] s, input logic q);
        return (32'(s) << SCS_NXT_LSB) | (32'(sec) << SCS_SECONDARY_OSC_ENABLE_BIT) | 32'(q);
    endfunction
    function automatic int oi(input logic [2:0] s);
        case (s)
            SCS_SRC_PRI, SCS_SRC_PRIPLL: return 0;
            SCS_SRC_SEC:                 return 1;
            SCS_SRC_DCO:                 return 3;
            SCS_SRC_LOW_POWER_RC_OSC:                return 4;
            default:                     return 2;
        endcase
    endfunction
    task automatic pulses(input int k);
        int r;
        repeat (k) begin
            // Each level must last two samples or the input filter drops it.
            r = $urandom_range(3, 2);
            new_clk_pin <= 1'b1;
            repeat (r) @(posedge pclk);
            new_clk_pin <= 1'b0;
            repeat (r) @(posedge pclk);
        end
    endtask
    // Crystal starts get edges during the start-up wait; they must not count.
    task automatic sw(input logic [2:0] s, input logic xtal);
        logic [4:0] e;
        int         o, n;
        o = oi(cur);
        unlock();
        wr(SCS_OFF_CTRL, ctl(s, 1'b1));
        rd(SCS_OFF_CTRL, 32'h1, 32'h29);
        chk("osc_enable new", 33'(osc_enable[oi(s)]), 33'h1);
        chk("cpu_stall", 33'(cpu_stall), 33'h0);
        if (xtal) begin
            pulses(150);
            chk("sys_clk_sel early", 33'(sys_clk_sel), 33'(cur));
            repeat (800) @(posedge pclk);
            rd(SCS_OFF_CTRL, 32'h20, 32'h20);
        end
        pulses(9);
        repeat (8) @(posedge pclk);
        chk("sys_clk_sel at nine", 33'(sys_clk_sel), 33'(cur));
        pulses(1);
        n = 0;
        while (sys_clk_sel !== s && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("sys_clk_sel", 33'(sys_clk_sel), 33'(s));
        if (n >= 40) stop_test();
        rd(SCS_OFF_CTRL, (32'(s) << SCS_CUR_LSB) | ctl(s, 1'b0), 32'h7703);
        e = en | (5'h01 << oi(s));
        if (o != oi(s) && !(o == 4 && cfg[2:1] != 2'h0) && !(o == 1 && sec)) e[o] = 1'b0;
        chk("osc_enable", 33'(osc_enable), 33'(e));
        en = e;
        cur = s;
        rd(SCS_OFF_IRQ_STAT, 32'h1, 32'h3);
        chk("irq", 33'(irq), 33'h1);
        wr(SCS_OFF_IRQ_STAT, 32'h1);
        chk("irq", 33'(irq), 33'h0);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, new_clk_pin, sec} = 6'h00;
        {paddr, pwdata, pstrb, osc_ready_pin} = 49'h0_0000_0000_01E0;
        cur = SCS_SRC_FRC;
        en = 5'h04;
        cfg = 3'h1;
        void'($urandom(79));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(SCS_OFF_CTRL, 32'h0, 32'h7729);
        rd(SCS_OFF_OSC_RUN, 32'h4, 32'h1F);
        rd(SCS_OFF_CFG, 32'h1, 32'h7);
        apb(1'b1, 8'h20, $urandom, 33'h1_0000_0000, 33'h1_0000_0000);
        apb(1'b0, 8'h20, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        unlock();
        wr(SCS_OFF_CTRL, ctl(SCS_SRC_DCO, 1'b1));
        rd(SCS_OFF_CTRL, 32'h0, 32'h7001);
        wr(SCS_OFF_CFG, 32'h0);
        wr(SCS_OFF_IRQ_MASK, 32'h3);
        wr(SCS_OFF_CTRL, ctl(SCS_SRC_DCO, 1'b1));
        rd(SCS_OFF_CTRL, 32'h0, 32'h7001);
        unlock();
        wr(SCS_OFF_CTRL, ctl(SCS_SRC_FRC, 1'b1));
        repeat (3) @(posedge pclk);
        rd(SCS_OFF_CTRL, 32'h0, 32'h7001);
        rd(SCS_OFF_IRQ_STAT, 32'h2, 32'h3);
        chk("irq", 33'(irq), 33'h1);
        wr(SCS_OFF_IRQ_STAT, 32'h2);
        chk("irq", 33'(irq), 33'h0);
        sw(SCS_SRC_DCO, 1'b0);
        sec = 1'b1;
        sw(SCS_SRC_SEC, 1'b0);
        cfg = 3'h2;
        wr(SCS_OFF_CFG, 32'h2);
        sw(SCS_SRC_LOW_POWER_RC_OSC, 1'b0);
        sw(SCS_SRC_PRIPLL, 1'b1);
        sw(SCS_SRC_FRC, 1'b0);
        stop_test();
    end
endmodule // tb
`default_nettype wire
